// file: rng_pkg.sv
// Shared constants and types for the hybrid random generator
package rng_pkg;
    // Generator geometry
    localparam int STATE_W = 128;
    localparam int WORD_W = 32;
    // Health test limits
    localparam int REP_LIMIT = 32;
    localparam int WIN_LEN = 64;
    localparam int ONES_LO = 16;
    localparam int ONES_HI = 48;
    // Reset values
    localparam logic [STATE_W-1:0] STATE_RST = {STATE_W{1'h0}};
    localparam logic [WORD_W-1:0] WORD_RST = {WORD_W{1'h0}};
    // Mixing rotations and round constant
    localparam int ROT_A = 7;
    localparam int ROT_B = 19;
    localparam int ROT_C = 41;
    localparam logic [STATE_W-1:0] ROUND_K =
        128'h9E3779B97F4A7C15F39CC0605CEDC834;

    // Generator control states
    typedef enum logic [1:0] {
        ST_WAIT = 2'h0,
        ST_SEED = 2'h1,
        ST_RUN = 2'h2,
        ST_FAIL = 2'h3
    } drbg_state_t;
endpackage : rng_pkg

// file: rng_health_test.sv
// Entropy source health gate: total failure and online proportion tests
`timescale 1ns/1ps
module rng_health_test import rng_pkg::*; #(
    parameter int REP_MAX = REP_LIMIT,
    parameter int WIN = WIN_LEN,
    parameter int LO = ONES_LO,
    parameter int HI = ONES_HI
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic bit_in,
    output logic bit_ok_q,
    output logic bit_q,
    output logic total_fail_q,
    output logic online_fail_q,
    output logic startup_done_q
);
    localparam int RW = $clog2(REP_MAX + 1);
    localparam int WW = $clog2(WIN + 1);

    logic started_q;
    logic last_q;
    logic [RW-1:0] rep_cnt_q;
    logic [RW-1:0] rep_d;
    logic [WW-1:0] win_cnt_q;
    logic [WW-1:0] ones_q;
    logic [WW-1:0] ones_d;
    logic same;
    logic win_last;
    logic tf_d;
    logic of_d;

    // Run length of identical bits; a stuck source shows up as a long run
    assign same = started_q && (bit_in == last_q);
    assign rep_d = !same ? RW'(1) :
        (rep_cnt_q == RW'(REP_MAX)) ? rep_cnt_q : rep_cnt_q + RW'(1);
    assign tf_d = total_fail_q | (rep_d >= RW'(REP_MAX));

    // Ones count over short windows keeps detection latency low
    assign win_last = (win_cnt_q == WW'(WIN - 1));
    assign ones_d = ones_q + {{(WW-1){1'h0}}, bit_in};
    assign of_d = online_fail_q | (win_last &&
        (ones_d < WW'(LO) || ones_d > WW'(HI)));

    // Repetition counter, active from the very first bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            started_q <= 1'h0;
            last_q <= 1'h0;
            rep_cnt_q <= '0;
            total_fail_q <= 1'h0;
        end else if (clk_en) begin
            started_q <= 1'h1;
            last_q <= bit_in;
            rep_cnt_q <= rep_d;
            total_fail_q <= tf_d; // Sticky until reset
        end
    end

    // Window test runs on every bit, forever
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            win_cnt_q <= '0;
            ones_q <= '0;
            online_fail_q <= 1'h0;
            startup_done_q <= 1'h0;
        end else if (clk_en) begin
            online_fail_q <= of_d;
            if (win_last) begin
                win_cnt_q <= '0;
                ones_q <= '0;
                if (!of_d && !tf_d) begin
                    startup_done_q <= 1'h1;
                end
            end else begin
                win_cnt_q <= win_cnt_q + WW'(1);
                ones_q <= ones_d;
            end
        end
    end

    // Bit handed on only while both tests are clean
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bit_ok_q <= 1'h0;
            bit_q <= 1'h0;
        end else if (clk_en) begin
            bit_ok_q <= !tf_d && !of_d;
            bit_q <= bit_in; // Held while frozen, so no bit is used twice
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    rep_run_fail_a: assert property (
        clk_en && same && rep_cnt_q == RW'(REP_MAX - 1) |=> total_fail_q)
        else $error("long run of equal bits not flagged");
    win_bias_fail_a: assert property (
        clk_en && win_last && ones_d > WW'(HI) |=> online_fail_q && !bit_ok_q)
        else $error("biased window not flagged");
    fail_sticky_a: assert property (
        total_fail_q |=> total_fail_q [*3])
        else $error("total failure flag dropped");
    win_fail_c: cover property (online_fail_q && !total_fail_q);
endmodule : rng_health_test

// file: hybrid_drbg_with_trng_health_gate.sv
// Hybrid deterministic generator seeded by a health-gated entropy source
//
// Summary of operation
// - The generator state is loaded only from health-checked entropy bits.
// - A reseed request while running or seeding refreshes the whole state from entropy; after a failure it has no effect.
// - Random output is delivered as 32-bit words.
// - Each per-word state update is a one-way feed-forward mix.
// - Fresh entropy is folded into the state with every word produced except the first after each seed.
// - A total failure test runs from start-up and blocks all output.
// - After a total failure no word built from later bits is released.
// - An online proportion test runs at start-up and during operation.
// - Output waits for a clean first window and stops on any defect.
// - The online test works on short windows so defects show up soon.
// - The online test is applied to every raw bit, continuously.
`timescale 1ns/1ps
module hybrid_drbg_with_trng_health_gate import rng_pkg::*; #(
    parameter int REP_MAX = REP_LIMIT,
    parameter int WIN = WIN_LEN,
    parameter int LO = ONES_LO,
    parameter int HI = ONES_HI
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic raw_bit,
    input wire logic reseed_req,
    input wire logic word_take,
    output logic [WORD_W-1:0] rnd_word_q,
    output logic rnd_valid_q,
    output logic seeding_q,
    output logic total_fail_q,
    output logic online_fail_q
);
    localparam int SW = $clog2(STATE_W);
    localparam logic [SW-1:0] SEED_LAST = SW'(STATE_W - 1);

    drbg_state_t st_q;
    logic raw_s1_q;
    logic raw_s2_q;
    logic bit_ok;
    logic bit_val;
    logic startup_done;
    logic health_ok;
    logic [SW-1:0] seed_cnt_q;
    logic [STATE_W-1:0] pool_q;
    logic [STATE_W-1:0] pool_d;
    logic [STATE_W-1:0] state_q;
    logic seed_done;
    logic gen_fire;

    // Rotate left by a fixed amount
    function automatic logic [STATE_W-1:0] rotl(
        input logic [STATE_W-1:0] s,
        input int n
    );
        rotl = (s << n) | (s >> (STATE_W - n));
    endfunction : rotl

    // Nonlinear step with feed-forward, so the old state cannot be rebuilt
    function automatic logic [STATE_W-1:0] mix_step(
        input logic [STATE_W-1:0] s
    );
        mix_step = s ^ (rotl(s, ROT_A) & ~rotl(s, ROT_B)) ^
            rotl(s, ROT_C) ^ ROUND_K;
    endfunction : mix_step

    // Output word is a fold of a mixed copy, never the raw state
    function automatic logic [WORD_W-1:0] out_word(
        input logic [STATE_W-1:0] s
    );
        logic [STATE_W-1:0] x;
        x = mix_step(rotl(s, ROT_B));
        out_word = WORD_RST;
        for (int i = 0; i < STATE_W / WORD_W; i++) begin
            out_word = out_word ^ x[i*WORD_W +: WORD_W];
        end
    endfunction : out_word

    // Raw pin bit passes two flip-flops before any test looks at it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            raw_s1_q <= 1'h0;
            raw_s2_q <= 1'h0;
        end else if (clk_en) begin
            raw_s1_q <= raw_bit;
            raw_s2_q <= raw_s1_q;
        end
    end

    rng_health_test #(
        .REP_MAX(REP_MAX),
        .WIN(WIN),
        .LO(LO),
        .HI(HI)
    ) rng_health_test_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .bit_in(raw_s2_q),
        .bit_ok_q(bit_ok),
        .bit_q(bit_val),
        .total_fail_q(total_fail_q),
        .online_fail_q(online_fail_q),
        .startup_done_q(startup_done)
    );

    assign health_ok = !total_fail_q && !online_fail_q;
    assign pool_d = {pool_q[STATE_W-2:0], bit_val};
    assign seed_done = (st_q == ST_SEED) && bit_ok &&
        (seed_cnt_q == SEED_LAST);
    assign gen_fire = (st_q == ST_RUN) && health_ok && !reseed_req &&
        (!rnd_valid_q || word_take);

    // Control: wait for clean start, seed, run; a failure is terminal
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= ST_WAIT;
        end else if (clk_en) begin
            if (!health_ok) begin
                st_q <= ST_FAIL;
            end else begin
                case (st_q)
                    ST_WAIT: begin
                        if (startup_done) begin
                            st_q <= ST_SEED;
                        end
                    end
                    ST_SEED: begin
                        if (seed_done) begin
                            st_q <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (reseed_req) begin
                            st_q <= ST_SEED;
                        end
                    end
                    default: begin
                        st_q <= ST_FAIL;
                    end
                endcase
            end
        end
    end

    // Seed bit counter; a new request restarts collection from zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seed_cnt_q <= '0;
        end else if (clk_en) begin
            if (st_q != ST_SEED || reseed_req) begin
                seed_cnt_q <= '0;
            end else if (bit_ok) begin
                seed_cnt_q <= seed_cnt_q + SW'(1);
            end
        end
    end

    // Entropy pool takes every healthy bit, even while running
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pool_q <= STATE_RST;
        end else if (clk_en && bit_ok) begin
            pool_q <= pool_d;
        end
    end

    // Internal state: full load on seed, mixed update per word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= STATE_RST;
        end else if (clk_en) begin
            if (!health_ok) begin
                state_q <= STATE_RST; // Wipe so nothing tainted survives
            end else if (seed_done) begin
                state_q <= pool_d;
            end else if (gen_fire) begin
                state_q <= mix_step(state_q) ^ pool_q;
            end
        end
    end

    // Output slot; valid cleared at once on any block or reseed
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rnd_word_q <= WORD_RST;
            rnd_valid_q <= 1'h0;
            seeding_q <= 1'h0;
        end else if (clk_en) begin
            seeding_q <= (st_q == ST_SEED) && !seed_done;
            if (!health_ok) begin
                rnd_word_q <= WORD_RST;
                rnd_valid_q <= 1'h0;
            end else if (gen_fire) begin
                rnd_word_q <= out_word(state_q);
                rnd_valid_q <= 1'h1;
            end else if (st_q != ST_RUN || reseed_req) begin
                rnd_valid_q <= 1'h0;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    blocked_no_valid_a: assert property (
        clk_en && !health_ok |=> !rnd_valid_q && rnd_word_q == WORD_RST)
        else $error("word valid while health gate blocks");
    startup_block_a: assert property (
        !startup_done |-> !rnd_valid_q && st_q != ST_RUN)
        else $error("output before start-up test finished");
    fail_terminal_a: assert property (
        st_q == ST_FAIL |=> st_q == ST_FAIL [*4])
        else $error("left failure state without reset");
    seed_load_a: assert property (
        clk_en && health_ok && seed_done |=>
            st_q == ST_RUN && state_q == $past(pool_d))
        else $error("state not loaded from entropy pool");
    reseed_any_time_a: assert property (
        clk_en && health_ok && st_q == ST_RUN && reseed_req |=>
            st_q == ST_SEED && !rnd_valid_q && seed_cnt_q == '0)
        else $error("reseed request not honoured");
    word_update_a: assert property (
        clk_en && gen_fire |=> rnd_valid_q &&
            rnd_word_q == out_word($past(state_q)) &&
            state_q == (mix_step($past(state_q)) ^ $past(pool_q)))
        else $error("word or state update wrong");
    word_hold_a: assert property (
        clk_en && rnd_valid_q && !word_take && health_ok &&
            st_q == ST_RUN && !reseed_req |=>
            rnd_valid_q && $stable(rnd_word_q))
        else $error("offered word changed before taken");
    seed_len_a: assert property (
        clk_en && health_ok && st_q == ST_RUN && reseed_req |=>
            st_q == ST_SEED [*8])
        else $error("reseed finished too early");

    word_taken_c: cover property (rnd_valid_q && word_take);
    reseed_c: cover property (st_q == ST_RUN && reseed_req ##1
        st_q == ST_SEED);
    failure_c: cover property (st_q == ST_RUN ##1 st_q == ST_FAIL);
endmodule : hybrid_drbg_with_trng_health_gate

// file: requester_model.sv
// Requester model that takes offered random words
`timescale 1ns/1ps
module requester_model import rng_pkg::*; (
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic take_en,
    input wire logic [WORD_W-1:0] rnd_word_q,
    input wire logic rnd_valid_q,
    output logic word_take,
    output logic [WORD_W-1:0] last_word,
    output logic [WORD_W-1:0] prev_word,
    output int taken_n
);
    // Take is a plain level; the bench moves it only at falling edges
    assign word_take = take_en;

    // One process owns the outputs; nothing taken before the first word
    initial begin
        last_word = WORD_RST;
        prev_word = WORD_RST;
        taken_n = 0;
        forever begin
            @(posedge sys_clk);
            // A word counts only on an enabled edge with valid high
            if (clk_en && word_take && rnd_valid_q === 1'b1) begin
                prev_word <= last_word;
                last_word <= rnd_word_q;
                taken_n <= taken_n + 1;
            end
        end
    end
endmodule : requester_model

// file: hybrid_drbg_with_trng_health_gate_tb.sv
// Self-checking bench for the health-gated hybrid generator
`timescale 1ns/1ps
module hybrid_drbg_with_trng_health_gate_tb import rng_pkg::*; ;
    // Short health windows keep the run brief
    localparam int WIN_T = 16;
    localparam int REP_T = 12;
    localparam int LIMIT = 4000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic raw_bit = 1'b0;
    logic reseed_req = 1'b0;
    logic take_en = 1'b0;
    logic word_take, rnd_valid_q, seeding_q, total_fail_q, online_fail_q;
    logic [WORD_W-1:0] rnd_word_q, last_word, prev_word, w0;
    logic [7:0] pat = 8'h35;
    int taken_n, n0, cyc = 0, ph = 0;
    int bad_count = 0;
    int cmp_count = 0;
    bit hit;

    // Free-running clock, 100 ns period
    always #50 sys_clk = ~sys_clk;

    // Entropy stand-in: repeating 8-bit pattern, one bit per cycle
    always @(negedge sys_clk) begin
        raw_bit <= pat[ph[2:0]];
        ph <= ph + 1;
    end

    hybrid_drbg_with_trng_health_gate #(.REP_MAX(REP_T), .WIN(WIN_T),
        .LO(4), .HI(12)) hybrid_drbg_with_trng_health_gate_inst (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .raw_bit(raw_bit),
        .reseed_req(reseed_req), .word_take(word_take),
        .rnd_word_q(rnd_word_q), .rnd_valid_q(rnd_valid_q),
        .seeding_q(seeding_q), .total_fail_q(total_fail_q),
        .online_fail_q(online_fail_q));

    requester_model requester_model_inst (
        .sys_clk(sys_clk), .clk_en(clk_en), .take_en(take_en),
        .rnd_word_q(rnd_word_q), .rnd_valid_q(rnd_valid_q),
        .word_take(word_take), .last_word(last_word),
        .prev_word(prev_word), .taken_n(taken_n));

    // Hang guard: a stuck wait ends the run as a failure
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            results();
        end
    end

    task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check

    task results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task cycles(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cycles

    // Bounded wait: 0 valid, 1 seeding, 2 total, 3 online, 4 either fault
    task wait_for(input int sel, input int lim, output bit seen);
        logic [4:0] f;
        seen = 1'b0;
        repeat (lim) begin
            @(negedge sys_clk);
            f = {total_fail_q | online_fail_q, online_fail_q, total_fail_q,
                seeding_q, rnd_valid_q};
            if (f[sel] === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask : wait_for

    task do_reset(input logic [7:0] p);
        pat = p;
        rst = 1'b1;
        cycles(4);
        rst = 1'b0;
    endtask : do_reset

    // Power-up: quiet until a clean window and a full seed
    task s_boot();
        do_reset(8'h35);
        check({rnd_valid_q, seeding_q}, 2'h0);
        check({total_fail_q, online_fail_q}, 2'h0);
        check(rnd_word_q, WORD_RST);
        wait_for(1, 3 * WIN_T, hit);
        check(hit, 1'b1);
        check(rnd_valid_q, 1'b0);
        wait_for(0, 200, hit);
        check(hit, 1'b1);
        check({total_fail_q, online_fail_q}, 2'h0);
    endtask : s_boot

    // Held word, back-to-back takes, then a frozen clock enable
    task s_stream();
        w0 = rnd_word_q;
        cycles(3);
        check(rnd_word_q, w0);
        n0 = taken_n;
        take_en = 1'b1;
        repeat (4) begin
            @(negedge sys_clk);
            check(rnd_valid_q, 1'b1);
        end
        check(taken_n - n0, 32'h4);
        check(last_word !== prev_word, 1'b1);
        check(last_word !== w0, 1'b1);
        clk_en = 1'b0;
        n0 = taken_n;
        w0 = rnd_word_q;
        cycles(3);
        check(taken_n - n0, 32'h0);
        check(rnd_word_q, w0);
        check({rnd_valid_q, seeding_q}, 2'h2);
        clk_en = 1'b1;
        take_en = 1'b0;
    endtask : s_stream

    // Reseed held over several edges restarts collection
    task s_reseed();
        w0 = rnd_word_q;
        reseed_req = 1'b1;
        repeat (3) begin
            @(negedge sys_clk);
            check(rnd_valid_q, 1'b0);
        end
        reseed_req = 1'b0;
        @(negedge sys_clk);
        check(seeding_q, 1'b1);
        wait_for(0, 200, hit);
        check(hit, 1'b1);
        check(rnd_word_q !== w0, 1'b1);
    endtask : s_reseed

    // Fault while running: word wiped, reseed cannot revive output
    task s_run_fault(input logic [7:0] p, input int sel, input int lim);
        pat = p;
        wait_for(sel, lim, hit);
        check(hit, 1'b1);
        @(negedge sys_clk);
        check(rnd_valid_q, 1'b0);
        check(rnd_word_q, WORD_RST);
        reseed_req = 1'b1;
        wait_for(0, 140, hit);
        check(hit, 1'b0);
        reseed_req = 1'b0;
    endtask : s_run_fault

    // Faulty source from reset: no word is ever offered
    task s_start_fault(input logic [7:0] p, input int sel);
        do_reset(p);
        wait_for(sel, 3 * WIN_T, hit);
        check(hit, 1'b1);
        wait_for(0, 200, hit);
        check(hit, 1'b0);
    endtask : s_start_fault

    // Main sequence; stuck and sparse sources after a clean phase, then stuck, sparse and dense sources from reset
    initial begin
        s_boot();
        s_stream();
        s_reseed();
        s_run_fault(8'hFF, 4, REP_T + 8);
        s_boot();
        s_run_fault(8'h01, 3, 2 * WIN_T + 8);
        s_start_fault(8'h00, 2);
        s_start_fault(8'h01, 3);
        // Too many ones per window, yet runs stay short of the run limit
        s_start_fault(8'hFE, 3);
        results();
    end
endmodule : hybrid_drbg_with_trng_health_gate_tb
